// ===== core/tmz_defs.svh
// Register map, field positions, reset values and timing counts for the
// timer0 block with its shared scaler.
// Assumes an include from the package or the design file, by bare name.
`ifndef TMZ_DEFS_SVH
`define TMZ_DEFS_SVH

// ==========================================================================
// Register offsets
`define TMZ_OFS_COUNT        8'h01
`define TMZ_OFS_INTCTL       8'h0B
`define TMZ_OFS_OPTION       8'h81
`define TMZ_OFS_PORTA_DIR    8'h85
`define TMZ_OFS_IRQ_STATUS   8'h90
`define TMZ_OFS_IRQ_CLEAR    8'h91
`define TMZ_OFS_IRQ_ENABLE   8'h92

// ==========================================================================
// Field positions
`define TMZ_INTCTL_OVF_FLAG  2
`define TMZ_INTCTL_OVF_EN    5
`define TMZ_IRQ_OVF          0
`define TMZ_IRQ_WDT          1
`define TMZ_IRQ_W            2

// ==========================================================================
// Reset values
`define TMZ_RST_COUNT        8'h00
`define TMZ_RST_INTCTL       8'h00
`define TMZ_RST_OPTION       8'hFF
`define TMZ_RST_PORTA_DIR    6'h3F

// ==========================================================================
// Timing
`define TMZ_CLK_NS           50
`define TMZ_INSTR_NS         200
`define TMZ_INSTR_CLKS       (`TMZ_INSTR_NS / `TMZ_CLK_NS)
`define TMZ_INHIBIT_INSTR    2
`define TMZ_WDT_BASE_CLKS    20000

`endif

// ===== core/tmz_pkg.sv
// Types shared by the timer0 block and its users.
// Assumes tmz_defs.svh sits beside it.
`include "tmz_defs.svh"

package tmz_pkg;

    // ======================================================================
    // Option register layout, bit 7 first
    typedef struct packed {
        logic       pullup_off;
        logic       int_edge;
        logic       clock_source_select;
        logic       edge_select;
        logic       scaler_assignment;
        logic [2:0] scaler_ratio;
    } tmz_option_t;

    // ======================================================================
    // One register access from the processor side
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tmz_req_t;

endpackage : tmz_pkg

// ===== core/tmz_timer0.sv
// Timer0 with an 8-bit scaler shared with the watchdog.
// Assumes the core clock at 20 MHz, a processor-side register port with
// one-cycle strobes, and an external count pin from outside the clock.
//
// Function
// R1 - Timer mode counts once per instruction cycle without prescaler.
// R2 - A count write blocks counting for the next two instruction cycles.
// R3 - Counter mode counts pin edges; edge select clear rising, set falling.
// R4 - Pin is synchronised before counting; count advances after a delay.
// R5 - One 8-bit scaler serves timer or watchdog, never both.
// R6 - Scaler contents are not visible or writable through any register.
// R7 - Option bits 3:0 hold scaler assignment and ratio.
// R8 - Scaler on timer divides from 1:2 to 1:256.
// R9 - Scaler on watchdog divides from 1:1 to 1:128.
// R10 - Ratio n gives 2^(n+1) for timer, 2^n for watchdog.
// R11 - Count write clears scaler when on timer; assignment and ratio kept.
// R12 - Clear-watchdog instruction clears scaler and watchdog when assigned.
// R13 - Scaler assignment may change any time without stopping timer.
// R14 - Software uses the safe sequence when moving scaler to watchdog.
// R15 - Rollover from FFh to 00h sets the overflow flag, bit 2.
// R16 - Overflow request masked while enable bit 5 is clear.
// R17 - Software clears the flag; hardware never clears it.
// R18 - Timer stops in sleep, so overflow never wakes the core.
// R19 - Flag sets on every rollover; enable gates only the request.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "tmz_defs.svh"

module tmz_timer0
    import tmz_pkg::*;
#(
    parameter int WDT_BASE_CLKS = `TMZ_WDT_BASE_CLKS,
    parameter int WDT_W         = 8
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire tmz_req_t   req_i,
    output logic [7:0]      rdata_o,
    input  wire logic       count_pin_i,
    input  wire logic       sleep_i,
    input  wire logic       clear_watchdog_i,
    input  wire logic       wdt_enable_i,
    output logic            overflow_req_o,
    output logic            wdt_timeout_o,
    output logic [5:0]      porta_dir_o,
    output logic            irq_o
);

    localparam int BASE_W = $clog2(WDT_BASE_CLKS + 1);

    // ======================================================================
    // Registers
    logic [7:0]             count_r;
    logic [7:0]             intctl_r;
    tmz_option_t            option_r;
    logic [5:0]             porta_dir_r;
    logic [`TMZ_IRQ_W-1:0]  irq_status_r;
    logic [`TMZ_IRQ_W-1:0]  irq_enable_r;
    logic [7:0]             rdata_r;

    logic [1:0]             phase_r;
    logic                   instr_en;
    logic [1:0]             inhibit_r;
    logic                   pin_s1_r;
    logic                   pin_s2_r;
    logic                   pin_s3_r;
    logic                   sel_edge;
    logic                   ext_tick_r;
    logic                   src_tick;
    logic                   gated_tick;
    logic [7:0]             scaler_r;
    logic [7:0]             ratio_mask;
    logic                   scaler_in;
    logic                   scaler_out;
    logic                   timer_inc;
    logic                   wdt_tick;
    logic                   overflow;
    logic [BASE_W-1:0]      base_cnt_r;
    logic                   base_tick;
    logic [WDT_W-1:0]       wdt_cnt_r;
    logic                   wdt_timeout_r;

    logic wr_count;
    logic wr_intctl;
    logic wr_option;
    logic wr_dir;
    logic wr_irq_clr;
    logic wr_irq_en;

    assign wr_count   = req_i.wr && (req_i.addr == `TMZ_OFS_COUNT);
    assign wr_intctl  = req_i.wr && (req_i.addr == `TMZ_OFS_INTCTL);
    assign wr_option  = req_i.wr && (req_i.addr == `TMZ_OFS_OPTION);
    assign wr_dir     = req_i.wr && (req_i.addr == `TMZ_OFS_PORTA_DIR);
    assign wr_irq_clr = req_i.wr && (req_i.addr == `TMZ_OFS_IRQ_CLEAR);
    assign wr_irq_en  = req_i.wr && (req_i.addr == `TMZ_OFS_IRQ_ENABLE);

    // ======================================================================
    // Instruction-cycle enable: one pulse every four core clocks
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_r <= 2'h0;
        end else begin
            phase_r <= phase_r + 2'h1;
        end
    end
    assign instr_en = (phase_r == 2'(`TMZ_INSTR_CLKS - 1));

    // ======================================================================
    // External pin: two-flop synchroniser, then edge pick and one stage of
    // delay; pulses narrower than a core clock can be missed
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_s1_r   <= 1'b0;
            pin_s2_r   <= 1'b0;
            pin_s3_r   <= 1'b0;
            ext_tick_r <= 1'b0;
        end else begin
            pin_s1_r   <= count_pin_i;
            pin_s2_r   <= pin_s1_r;                                   // [R4]
            pin_s3_r   <= pin_s2_r;
            ext_tick_r <= sel_edge;                                   // [R4]
        end
    end
    assign sel_edge = option_r.edge_select ? (pin_s3_r && !pin_s2_r)
                                           : (!pin_s3_r && pin_s2_r); // [R3]

    // ======================================================================
    // Source selection, sleep stop and post-write inhibit
    assign src_tick   = option_r.clock_source_select ? ext_tick_r
                                                     : instr_en;  // [R1] [R3]
    assign gated_tick = src_tick && !sleep_i && (inhibit_r == 2'h0);
                                                                  // [R2] [R18]

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            inhibit_r <= 2'h0;
        end else if (wr_count) begin
            inhibit_r <= 2'(`TMZ_INHIBIT_INSTR);                     // [R2]
        end else if (instr_en && inhibit_r != 2'h0) begin
            inhibit_r <= inhibit_r - 2'h1;
        end
    end

    // ======================================================================
    // Shared scaler; no register path reads or loads it
    function automatic logic [7:0] ratio_mask_f(input logic to_wdt,
                                                input logic [2:0] n);
        logic [8:0] span;
        span = to_wdt ? (9'h001 << n) : (9'h002 << n);               // [R10]
        return 8'(span - 9'h001);
    endfunction

    assign ratio_mask = ratio_mask_f(option_r.scaler_assignment,
                                     option_r.scaler_ratio);           // [R7]
    assign scaler_in  = option_r.scaler_assignment ? base_tick
                                                   : gated_tick;      // [R5]
    assign scaler_out = scaler_in &&
                        ((scaler_r & ratio_mask) == ratio_mask);  // [R8] [R9]
    assign timer_inc  = option_r.scaler_assignment ? gated_tick
                                                   : scaler_out;      // [R5]
    assign wdt_tick   = option_r.scaler_assignment ? scaler_out
                                                   : base_tick;       // [R5]

    // Assignment is read live, so a change takes effect on the next tick
    // without stopping the timer
    always_ff @(posedge clk_i or negedge rst_n_i) begin               // [R13]
        if (!rst_n_i) begin
            scaler_r <= 8'h00;
        end else if (wr_count && !option_r.scaler_assignment) begin
            scaler_r <= 8'h00;                                        // [R11]
        end else if (clear_watchdog_i && option_r.scaler_assignment) begin
            scaler_r <= 8'h00;                                        // [R12]
        end else if (scaler_in) begin
            scaler_r <= scaler_r + 8'h01;                             // [R6]
        end
    end

    // ======================================================================
    // Count register
    assign overflow = timer_inc && (count_r == 8'hFF);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_r <= `TMZ_RST_COUNT;
        end else if (wr_count) begin
            count_r <= req_i.wdata;
        end else if (timer_inc) begin
            count_r <= count_r + 8'h01;                               // [R1]
        end
    end

    // ======================================================================
    // Interrupt control: the overflow flag wins over a clearing write
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            intctl_r <= `TMZ_RST_INTCTL;
        end else if (wr_intctl) begin
            intctl_r <= req_i.wdata;
            intctl_r[`TMZ_INTCTL_OVF_FLAG] <=
                req_i.wdata[`TMZ_INTCTL_OVF_FLAG] || overflow;        // [R17]
        end else if (overflow) begin
            intctl_r[`TMZ_INTCTL_OVF_FLAG] <= 1'b1;           // [R15] [R19]
        end
    end
    assign overflow_req_o = intctl_r[`TMZ_INTCTL_OVF_EN] &&
                            intctl_r[`TMZ_INTCTL_OVF_FLAG];           // [R16]

    // ======================================================================
    // Option and port direction
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            option_r <= tmz_option_t'(`TMZ_RST_OPTION);
        end else if (wr_option) begin
            option_r <= tmz_option_t'(req_i.wdata);                   // [R7]
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            porta_dir_r <= `TMZ_RST_PORTA_DIR;
        end else if (wr_dir) begin
            porta_dir_r <= req_i.wdata[5:0];
        end
    end
    assign porta_dir_o = porta_dir_r;

    // ======================================================================
    // Watchdog: base divider stands in for its own oscillator and keeps
    // running in sleep
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            base_cnt_r <= '0;
        end else if (base_tick) begin
            base_cnt_r <= '0;
        end else begin
            base_cnt_r <= base_cnt_r + 1'b1;
        end
    end
    assign base_tick = (base_cnt_r == BASE_W'(WDT_BASE_CLKS - 1));

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wdt_cnt_r     <= '0;
            wdt_timeout_r <= 1'b0;
        end else begin
            wdt_timeout_r <= 1'b0;
            if (clear_watchdog_i) begin
                wdt_cnt_r <= '0;                                      // [R12]
            end else if (wdt_enable_i && wdt_tick) begin
                wdt_cnt_r <= wdt_cnt_r + 1'b1;
                wdt_timeout_r <= &wdt_cnt_r;
            end
        end
    end
    assign wdt_timeout_o = wdt_timeout_r;

    // ======================================================================
    // Interrupt status, clear and enable; an event beats a clear
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_status_r <= '0;
        end else begin
            irq_status_r <= (irq_status_r &
                             ~(wr_irq_clr ? req_i.wdata[`TMZ_IRQ_W-1:0]
                                          : '0)) |
                            {wdt_timeout_r, overflow};
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_enable_r <= '0;
        end else if (wr_irq_en) begin
            irq_enable_r <= req_i.wdata[`TMZ_IRQ_W-1:0];
        end
    end
    assign irq_o = |(irq_status_r & irq_enable_r);

    // ======================================================================
    // Read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_r <= 8'h00;
        end else if (req_i.rd) begin
            unique case (req_i.addr)
                `TMZ_OFS_COUNT:      rdata_r <= count_r;
                `TMZ_OFS_INTCTL:     rdata_r <= intctl_r;
                `TMZ_OFS_OPTION:     rdata_r <= option_r;
                `TMZ_OFS_PORTA_DIR:  rdata_r <= {2'h0, porta_dir_r};
                `TMZ_OFS_IRQ_STATUS: rdata_r <= 8'(irq_status_r);
                `TMZ_OFS_IRQ_ENABLE: rdata_r <= 8'(irq_enable_r);
                default:             rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end
    assign rdata_o = rdata_r;

    // ======================================================================
    // Assertions
    a_timer_mode_rate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!option_r.clock_source_select && option_r.scaler_assignment &&
         instr_en && !sleep_i && inhibit_r == 2'h0 && !wr_count)
        |=> count_r == $past(count_r) + 8'h01)  // [R1]
        else $error("timer mode did not count the instruction cycle");

    a_write_inhibit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_count |=> (!timer_inc)[*4])  // [R2]
        else $error("count advanced right after a write");

    a_ext_edge_sync: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (option_r.clock_source_select && $rose(ext_tick_r))
        |-> $past(pin_s2_r, 1) != $past(pin_s3_r, 1))  // [R4]
        else $error("external tick without a synchronised edge");

    a_prescale_ratio: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!option_r.scaler_assignment && timer_inc)
        |-> (scaler_r & ratio_mask) == ratio_mask)  // [R8]
        else $error("timer ticked before the scaler wrapped");

    a_scaler_wr_clr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_count && !option_r.scaler_assignment && !wr_option)
        |=> scaler_r == 8'h00 && option_r == $past(option_r))  // [R11]
        else $error("count write did not clear the scaler");

    a_scaler_wdt_clr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (clear_watchdog_i && option_r.scaler_assignment && !wr_count)
        |=> scaler_r == 8'h00 && wdt_cnt_r == '0)  // [R12]
        else $error("watchdog clear missed scaler or counter");

    a_roll_sets_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (timer_inc && count_r == 8'hFF && !wr_count)
        |=> count_r == 8'h00 && intctl_r[`TMZ_INTCTL_OVF_FLAG])  // [R15]
        else $error("rollover did not set the overflow flag");

    a_request_masked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(overflow_req_o) |-> intctl_r[`TMZ_INTCTL_OVF_EN])  // [R16]
        else $error("overflow request raised while masked");

    a_sleep_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (sleep_i && !wr_count) |=> count_r == $past(count_r))  // [R18]
        else $error("count moved during sleep");

endmodule // tmz_timer0

`default_nettype wire

// ===== verification/tmz_pin_src.sv
// External count source for the timer pin of the timer0 block.
// Assumes the bench clock; toggles every HALF clocks while run_i is high
// and holds its level otherwise, so the bench knows the edge count.
`timescale 1ns/100ps
`default_nettype none

module tmz_pin_src #(
    parameter int HALF = 3
) (
    input  wire logic clk_i,
    input  wire logic run_i,
    output logic      pin_o
);
    int ph = 0;

    initial pin_o = 1'b0;

    // ======================================================================
    // Toggle
    // Levels last HALF clocks so the two-flop synchroniser sees each one
    always @(posedge clk_i) begin
        if (run_i !== 1'b1) begin
            ph <= 0;
        end else if (ph == HALF - 1) begin
            ph    <= 0;
            pin_o <= ~pin_o;
        end else begin
            ph <= ph + 1;
        end
    end
endmodule // tmz_pin_src
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the timer0 block with its shared scaler.
// Assumes the design's register port, a pin source model and short
// watchdog counts (base 8 clocks, 2-bit watchdog counter).
`timescale 1ns/100ps
`default_nettype none

module tb_top
    import tmz_pkg::*;
;
    localparam int WB   = 8;
    localparam int HALF = 3;

    logic       clk_i       = 1'b0;
    logic       rst_n_i     = 1'b0;
    tmz_req_t   req         = '0;
    logic       run         = 1'b0;
    logic       sleep       = 1'b0;
    logic       clrw        = 1'b0;
    logic       wdt_en      = 1'b0;
    logic [7:0] rdata;
    logic       pin;
    logic       ovf_req;
    logic       wdt_to;
    logic [5:0] pdir;
    logic       irq;
    int         errors      = 0;
    int         check_count = 0;
    int         cyc         = 0;
    int         seed        = 32'h1ab9b787;
    int         g;
    int         k;
    logic [7:0] v;
    logic [7:0] w;
    logic [7:0] ra [6] = '{8'h01, 8'h0B, 8'h81, 8'h85, 8'h92, 8'h40};
    logic [7:0] rv [6] = '{8'h00, 8'h00, 8'hFF, 8'h3F, 8'h00, 8'h00};

    always #25 clk_i = ~clk_i;

    tmz_timer0 #(.WDT_BASE_CLKS(WB), .WDT_W(2)) dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .rdata_o(rdata),
        .count_pin_i(pin), .sleep_i(sleep), .clear_watchdog_i(clrw),
        .wdt_enable_i(wdt_en), .overflow_req_o(ovf_req),
        .wdt_timeout_o(wdt_to), .porta_dir_o(pdir), .irq_o(irq));

    tmz_pin_src #(.HALF(HALF)) src (.clk_i(clk_i), .run_i(run), .pin_o(pin));

    // ======================================================================
    // Checking and reporting
    task automatic wrap_up;
        if (errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic chk_gap(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            errors++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    // Cycle count since release; also cuts a hang short
    always @(posedge clk_i) begin
        cyc <= rst_n_i ? cyc + 1 : 0;
        if (cyc > 100000) begin
            errors++;
            wrap_up();
        end
    end

    function automatic logic [7:0] inhib_add(input int n);
        return (n > 2) ? 8'(n - 2) : 8'h00;
    endfunction

    function automatic int wdt_per(input int n);
        return (WB * 4) << n;
    endfunction

    // ======================================================================
    // Register port, strobes launched right after a rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_i);
        req <= '0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_i);
        req <= '0;
        @(negedge clk_i);
        d = rdata;
        @(posedge clk_i);
    endtask

    // Leaves the caller just after an instruction-cycle edge
    task automatic sync;
        do @(negedge clk_i); while (cyc % 4 != 3);
        @(posedge clk_i);
    endtask

    task automatic rate(input int d, input logic [7:0] exp_inc);
        rd(8'h01, v);
        repeat (d - 2) @(posedge clk_i);
        rd(8'h01, w);
        chk_reg(w - v, exp_inc);
    endtask

    task automatic gap(output int n);
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (wdt_to !== 1'b1 && n < 5000);
        // Hand back just after a rising edge so strobes launch there
        @(posedge clk_i);
    endtask

    // ======================================================================
    // Scenarios
    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        for (k = 0; k < 6; k++) begin
            rd(ra[k], v);
            chk_reg(v, rv[k]);
        end
        w = 8'($random(seed));
        wr(8'h85, w);
        rd(8'h85, v);
        chk_reg(v, {2'b00, w[5:0]});
        chk_reg({2'b00, pdir}, {2'b00, w[5:0]});
        wr(8'h81, 8'h08);
        rate(40, 8'd10);
        sleep <= 1'b1;
        rate(40, 8'd0);
        sleep <= 1'b0;
        for (k = 1; k < 5; k++) begin
            sync();
            w = 8'($random(seed));
            wr(8'h01, w);
            repeat (4 * k - 2) @(posedge clk_i);
            rd(8'h01, v);
            chk_reg(v, w + inhib_add(k));
        end
        for (k = 0; k < 8; k++) begin
            wr(8'h81, k[7:0]);
            rate(8 << (k + 1), 8'd2);
        end
        repeat (4) begin
            wr(8'h01, 8'h40);
            repeat (600) @(posedge clk_i);
        end
        rd(8'h01, v);
        chk_reg(v, 8'h40);
        rd(8'h81, v);
        chk_reg(v, 8'h07);
        wr(8'h81, 8'h08);
        wr(8'h0B, 8'h00);
        wr(8'h01, 8'hFE);
        repeat (40) @(posedge clk_i);
        rd(8'h0B, v);
        chk_reg(v, 8'h04);
        chk_flag(ovf_req, 1'b0);
        chk_flag(irq, 1'b0);
        rd(8'h90, v);
        chk_flag(v[0], 1'b1);
        wr(8'h92, 8'h01);
        chk_flag(irq, 1'b1);
        wr(8'h91, 8'h01);
        chk_flag(irq, 1'b0);
        wr(8'h0B, 8'h20);
        chk_flag(ovf_req, 1'b0);
        repeat (1100) @(posedge clk_i);
        rd(8'h0B, v);
        chk_reg(v, 8'h24);
        chk_flag(ovf_req, 1'b1);
        chk_flag(irq, 1'b1);
        for (k = 0; k < 2; k++) begin
            g = 1 + ($random(seed) & 7);
            wr(8'h81, k ? 8'h38 : 8'h28);
            wr(8'h01, 8'h00);
            repeat (20) @(posedge clk_i);
            run <= 1'b1;
            repeat ((2 * g - 1) * HALF) @(posedge clk_i);
            run <= 1'b0;
            repeat (10) @(posedge clk_i);
            rd(8'h01, v);
            chk_reg(v, 8'(g - k));
            run <= 1'b1;
            repeat (HALF) @(posedge clk_i);
            run <= 1'b0;
        end
        wdt_en <= 1'b1;
        wr(8'h81, 8'h07);
        gap(g);
        gap(g);
        gap(g);
        chk_gap(g, wdt_per(0));
        // Safe move from timer to watchdog: clear watchdog, then scaler
        clrw <= 1'b1;
        @(posedge clk_i);
        clrw <= 1'b0;
        wr(8'h01, 8'h00);
        for (k = 0; k < 8; k++) begin
            wr(8'h81, 8'h08 | k[7:0]);
            gap(g);
            gap(g);
            gap(g);
            chk_gap(g, wdt_per(k));
        end
        wr(8'h81, 8'h0A);
        rate(40, 8'd10);
        gap(g);
        repeat (60) @(posedge clk_i);
        clrw <= 1'b1;
        @(posedge clk_i);
        clrw <= 1'b0;
        gap(g);
        chk_flag(g > wdt_per(2) - WB, 1'b1);
        @(posedge clk_i);
        rd(8'h90, v);
        chk_flag(v[1], 1'b1);
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
